//--- shared/quh_regs.vh
// constants for the quad uart host port
`ifndef QUH_REGS_VH
`define QUH_REGS_VH
`define QUH_REG_SEL_MSB      3
`define QUH_CH_SEL_LSB       4
`define QUH_CH_SEL_MSB       6
`define QUH_GLOBAL_BIT       7
`define QUH_OFF_IER          4'h1
`define QUH_OFF_MCR          4'h4
`define QUH_OFF_MSR          4'h6
`define QUH_OFF_FEATURE_CONTROL_REG         4'h8
`define QUH_OFF_EFR          4'h9
`define QUH_MCR_DTR_BIT      0
`define QUH_MCR_RTS_BIT      1
`define QUH_MCR_SEL_BIT      2
`define QUH_FEATURE_CONTROL_REG_RS485_BIT   5
`define QUH_FEATURE_CONTROL_REG_IRINV_BIT   4
`define QUH_EFR_AUTOOUT_BIT  6
`define QUH_EFR_AUTOIN_BIT   7
`define QUH_IER_MODEM_BIT    3
`define QUH_RESET_BYTE       8'h00
// id value is arbitrary
`define QUH_GLOBAL_ID        8'h5A
`endif

//--- src/quh_host_port.v
// host bus access and modem pin control for a four channel uart
// How it works
// R1: address bits 3..0 pick one of sixteen registers of the addressed channel.
// R2: address bits 6..4 pick the serial channel, only 0 to 3 are populated.
// R3: address bit 7 steers the access to the global register set.
// R4: in separate strobe mode the read strobe falling edge starts a read driving the data bus.
// R5: in separate strobe mode the write strobe returning edge stores the data byte; the code stores it when strobe or chip select ends, whichever is first.
// R6: in separate strobe mode chip select low is needed for any access.
// R7: in single strobe mode the write strobe pin is the direction line, high read, low write.
// R8: in single strobe mode chip select is the strobe timing reads and writes.
// R9: all channel interrupts share one open drain active low output.
// R10: the far side holds each receive input high when idle outside infrared use.
// R11: feature control bit 4 inverts received infrared pulses before the decoder.
// R12: request to send is a plain output or, with enhanced bit 6, auto flow control.
// R13: terminal ready likewise, with modem control bit 2 choosing which pin is used.
// R14: feature control bit 5 makes the chosen pin drive half duplex direction.
// R15: clear to send is a plain input or, with enhanced bit 7, gates transmission.
// R16: the data bus is driven only during a selected, strobed read.
`timescale 1ns/10ps
`include "quh_regs.vh"
module quh_host_port #(
	parameter NCH = 4
) (
	input  wire             clk,
	input  wire             reset_n,
	input  wire             bus_mode_sel,
	input  wire [7:0]       addr,
	input  wire [7:0]       data_in,
	output reg  [7:0]       data_out,
	output reg              data_oe_n,
	input  wire             read_strobe_n,
	input  wire             write_strobe_n,
	input  wire             chip_sel_n,
	output reg              irq_oe_n,
	input  wire [NCH-1:0]   rx_in,
	output reg  [NCH-1:0]   rx_to_decoder,
	input  wire [NCH-1:0]   cts_in_n,
	input  wire [NCH-1:0]   set_ready_in_n,
	input  wire [NCH-1:0]   ch_irq,
	input  wire [NCH-1:0]   rx_wants_hold,
	input  wire [NCH-1:0]   tx_busy,
	output reg  [NCH-1:0]   rts_out_n,
	output reg  [NCH-1:0]   terminal_ready_out_n,
	output reg  [NCH-1:0]   tx_allowed
);
	reg        rst_s1_reg;
	reg        rst_s2_reg;
	wire       rst_n = rst_s2_reg;
	reg        wr_prev_reg;
	reg        cs_prev_reg;
	reg [7:0]  global_reg;
	reg [7:0]  interrupt_enable_reg [0:NCH-1];
	reg [7:0]  modem_control_reg    [0:NCH-1];
	reg [7:0]  feature_control_reg  [0:NCH-1];
	reg [7:0]  enhanced_feature_reg [0:NCH-1];
	reg [7:0]  modem_status_reg     [0:NCH-1];

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	// R1: register offset
	wire [3:0] reg_sel = addr[`QUH_REG_SEL_MSB:0];
	// R2: channel select
	wire [2:0] ch_sel  = addr[`QUH_CH_SEL_MSB:`QUH_CH_SEL_LSB];
	// R3: global decode
	wire       glob    = addr[`QUH_GLOBAL_BIT];
	wire       ch_ok   = ({1'b0, ch_sel} < NCH);
	wire [1:0] ch      = ch_sel[1:0];

	// R4: intel read level, gated by chip select
	// R6: chip select enables
	wire intel_rd = bus_mode_sel & ~chip_sel_n & ~read_strobe_n;
	// R7: direction line high means read
	// R8: chip select is the strobe
	wire moto_rd  = ~bus_mode_sel & ~chip_sel_n & write_strobe_n;
	wire rd_act   = intel_rd | moto_rd;
	// R5: write lands on the returning strobe edge
	// strobe and select often rise together, so the end of either one closes the write
	wire intel_wr = bus_mode_sel & (write_strobe_n | chip_sel_n) & ~wr_prev_reg;
	// R8: write on chip select rising with direction low
	wire moto_wr  = ~bus_mode_sel & chip_sel_n & ~cs_prev_reg & ~write_strobe_n;
	wire wr_now   = intel_wr | moto_wr;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_prev_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
		end else begin
			wr_prev_reg <= write_strobe_n | chip_sel_n;
			cs_prev_reg <= chip_sel_n;
		end
	end

	reg [7:0] rd_byte;
	always @* begin
		rd_byte = `QUH_RESET_BYTE;
		if (glob) begin
			case (reg_sel)
				4'h0:    rd_byte = {{(8-NCH){1'b0}}, ch_irq};
				4'h1:    rd_byte = `QUH_GLOBAL_ID;
				4'h2:    rd_byte = global_reg;
				default: rd_byte = `QUH_RESET_BYTE;
			endcase
		end else if (ch_ok) begin
			case (reg_sel)
				`QUH_OFF_IER:  rd_byte = interrupt_enable_reg[ch];
				`QUH_OFF_MCR:  rd_byte = modem_control_reg[ch];
				`QUH_OFF_MSR:  rd_byte = modem_status_reg[ch];
				`QUH_OFF_FEATURE_CONTROL_REG: rd_byte = feature_control_reg[ch];
				`QUH_OFF_EFR:  rd_byte = enhanced_feature_reg[ch];
				default:       rd_byte = `QUH_RESET_BYTE;
			endcase
		end
	end

	// R16: bus released outside reads
	// R4: byte reloaded every clock while the read is active, held once it ends
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out  <= `QUH_RESET_BYTE;
			data_oe_n <= 1'b1;
		end else begin
			data_oe_n <= ~rd_act;
			if (rd_act)
				data_out <= rd_byte;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			global_reg <= `QUH_RESET_BYTE;
		else if (wr_now && glob && reg_sel == 4'h2)
			global_reg <= data_in;
	end

	wire [NCH-1:0] irq_pend;
	genvar i;
	generate
		for (i = 0; i < NCH; i = i + 1) begin : g_ch
			wire hit = wr_now & ~glob & ch_ok & (ch == i);
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					interrupt_enable_reg[i] <= `QUH_RESET_BYTE;
					modem_control_reg[i]    <= `QUH_RESET_BYTE;
					feature_control_reg[i]  <= `QUH_RESET_BYTE;
					enhanced_feature_reg[i] <= `QUH_RESET_BYTE;
					modem_status_reg[i]     <= `QUH_RESET_BYTE;
				end else begin
					if (hit && reg_sel == `QUH_OFF_IER)
						interrupt_enable_reg[i] <= data_in;
					if (hit && reg_sel == `QUH_OFF_MCR)
						modem_control_reg[i] <= data_in;
					if (hit && reg_sel == `QUH_OFF_FEATURE_CONTROL_REG)
						feature_control_reg[i] <= data_in;
					if (hit && reg_sel == `QUH_OFF_EFR)
						enhanced_feature_reg[i] <= data_in;
					modem_status_reg[i] <= {2'b00, ~set_ready_in_n[i], ~cts_in_n[i], 4'h0};
				end
			end
			wire use_dtr = modem_control_reg[i][`QUH_MCR_SEL_BIT];
			// R12: rts asserted through modem control first
			wire rts_on  = modem_control_reg[i][`QUH_MCR_RTS_BIT];
			// R13: dtr asserted through modem control first
			wire dtr_on  = modem_control_reg[i][`QUH_MCR_DTR_BIT];
			wire auto_o  = enhanced_feature_reg[i][`QUH_EFR_AUTOOUT_BIT];
			// R14: half duplex direction follows the transmitter
			wire rs485   = feature_control_reg[i][`QUH_FEATURE_CONTROL_REG_RS485_BIT];
			wire flow_o  = rs485 ? tx_busy[i] : ~(auto_o & rx_wants_hold[i]);
			// R15: cts or dsr gates transmission
			wire in_n    = use_dtr ? set_ready_in_n[i] : cts_in_n[i];
			wire auto_i  = enhanced_feature_reg[i][`QUH_EFR_AUTOIN_BIT];
			assign irq_pend[i] = ch_irq[i] &
				(interrupt_enable_reg[i] != `QUH_RESET_BYTE);
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					rts_out_n[i]            <= 1'b1;
					terminal_ready_out_n[i] <= 1'b1;
					tx_allowed[i]           <= 1'b1;
					rx_to_decoder[i]        <= 1'b1;
				end else begin
					// R12: rts plain or flow output
					rts_out_n[i] <= ~(rts_on & ((use_dtr | ~(auto_o | rs485)) | flow_o));
					// R13: dtr plain or flow output
					terminal_ready_out_n[i] <=
						~(dtr_on & ((~use_dtr | ~(auto_o | rs485)) | flow_o));
					tx_allowed[i] <= ~auto_i | ~in_n;
					// R11: infrared pulse inversion
					rx_to_decoder[i] <= rx_in[i] ^ feature_control_reg[i][`QUH_FEATURE_CONTROL_REG_IRINV_BIT];
				end
			end
		end
	endgenerate

	// R9: shared open drain, low enable means pulling low
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq_oe_n <= 1'b1;
		else
			irq_oe_n <= ~(|irq_pend);
	end
endmodule

//--- verif/quh_port_monitor_monitor.sv
// pin level checks on the host port
`timescale 1ns/10ps
module quh_port_monitor #(
	parameter NCH = 4
) (
	input wire           clk,
	input wire           reset_n,
	input wire           bus_mode_sel,
	input wire           read_strobe_n,
	input wire           write_strobe_n,
	input wire           chip_sel_n,
	input wire [7:0]     data_out,
	input wire           data_oe_n,
	input wire           irq_oe_n,
	input wire [NCH-1:0] ch_irq,
	input wire [NCH-1:0] cts_in_n,
	input wire [NCH-1:0] set_ready_in_n,
	input wire [NCH-1:0] tx_allowed
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire rd_sep = bus_mode_sel && !chip_sel_n && !read_strobe_n;
	wire rd_one = !bus_mode_sel && !chip_sel_n && write_strobe_n;
	a_sep_read: assert property (rd_sep |=> !data_oe_n)
		else $error("read not driven");
	a_one_read: assert property (rd_one |=> !data_oe_n)
		else $error("read not driven");
	a_one_write: assert property (!bus_mode_sel && !write_strobe_n |=> data_oe_n)
		else $error("driven on write");
	a_sep_write: assert property (bus_mode_sel && read_strobe_n |=> data_oe_n)
		else $error("driven on write");
	a_deselect_off: assert property (chip_sel_n |=> data_oe_n)
		else $error("driven while deselected");
	a_data_hold: assert property (chip_sel_n [*2] |=> $stable(data_out))
		else $error("data moved while idle");
	a_irq_quiet: assert property ((ch_irq == 0) [*2] |=> irq_oe_n)
		else $error("interrupt without cause");
	a_tx_free: assert property ((cts_in_n == 0 && set_ready_in_n == 0) [*2] |=> &tx_allowed)
		else $error("transmit held while clear");
	cover property (rd_sep);
	cover property (rd_one);
	cover property (!irq_oe_n);
endmodule
bind quh_host_port quh_port_monitor #(.NCH(NCH)) u_mon (.clk(clk), .reset_n(reset_n),
	.bus_mode_sel(bus_mode_sel), .read_strobe_n(read_strobe_n), .chip_sel_n(chip_sel_n),
	.write_strobe_n(write_strobe_n), .data_out(data_out), .data_oe_n(data_oe_n),
	.irq_oe_n(irq_oe_n), .ch_irq(ch_irq), .cts_in_n(cts_in_n),
	.set_ready_in_n(set_ready_in_n), .tx_allowed(tx_allowed));

//--- verif/quh_line_model.sv
// far end of the four serial lines
`timescale 1ns/10ps
module quh_line_model (
	input  wire       stall,
	output wire [3:0] rx_in,
	output wire [3:0] cts_in_n,
	output wire [3:0] set_ready_in_n
);
	assign rx_in = 4'hF;
	assign cts_in_n = {4{stall}};
	assign set_ready_in_n = {4{stall}};
endmodule

//--- verif/test_quad_uart_host_port.sv
// self-checking bench for the host port
`timescale 1ns/10ps
`include "quh_regs.vh"
module test_quad_uart_host_port;
	reg        clk = 1'b0;
	reg        reset_n = 1'b0;
	reg        mode = 1'b1;
	reg  [7:0] addr = 8'h00;
	reg  [7:0] data_in = 8'h00;
	reg        rd_n = 1'b1;
	reg        wr_n = 1'b1;
	reg        cs_n = 1'b1;
	reg  [3:0] ch_irq = 4'h0;
	reg  [3:0] hold = 4'h0;
	reg        stall = 1'b0;
	reg  [3:0] busy = 4'h0;
	wire [7:0] data_out;
	wire       oe_n;
	wire       irq_n;
	wire [3:0] rx, rxd, cts_n, dsr_n, rts_n, dtr_n, tx_ok;
	integer    fail_count = 0;
	integer    samples_checked = 0;
	integer    i;
	always #2 clk = ~clk;
	quh_line_model line (.stall(stall), .rx_in(rx), .cts_in_n(cts_n), .set_ready_in_n(dsr_n));
	quh_host_port dut (.clk(clk), .reset_n(reset_n), .bus_mode_sel(mode), .addr(addr),
		.data_in(data_in), .data_out(data_out), .data_oe_n(oe_n), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n), .chip_sel_n(cs_n), .irq_oe_n(irq_n), .rx_in(rx),
		.rx_to_decoder(rxd), .cts_in_n(cts_n), .set_ready_in_n(dsr_n), .ch_irq(ch_irq),
		.rx_wants_hold(hold), .tx_busy(busy), .rts_out_n(rts_n),
		.terminal_ready_out_n(dtr_n), .tx_allowed(tx_ok));
	task chk(input [7:0] got, input [7:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	end
	endtask
	// m=1 separate strobes, w=1 write; a read compares against d
	task acc(input m, input w, input [7:0] a, input [7:0] d);
	begin
		@(posedge clk);
		mode <= m;
		addr <= a;
		data_in <= d;
		cs_n <= 1'b0;
		rd_n <= !(m && !w);
		wr_n <= !w;
		repeat (2) @(posedge clk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		wr_n <= !(w && !m);
		#1;
		if (!w) chk(data_out, d);
		if (!w) chk({7'h00, oe_n}, 8'h00);
		@(posedge clk);
		wr_n <= 1'b1;
		@(posedge clk);
	end
	endtask
	task close_out;
	begin
		$display("checks %0d failures %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		acc(1'b1, 1'b0, 8'h81, `QUH_GLOBAL_ID);
		acc(1'b0, 1'b0, 8'h81, `QUH_GLOBAL_ID);
		acc(1'b1, 1'b1, 8'h82, 8'hA5);
		acc(1'b0, 1'b0, 8'h82, 8'hA5);
		acc(1'b0, 1'b1, 8'h82, 8'h3C);
		acc(1'b1, 1'b0, 8'h82, 8'h3C);
		for (i = 0; i < 4; i = i + 1)
			acc(1'b1, 1'b1, {1'b0, i[2:0], `QUH_OFF_IER}, 8'h11 + i[7:0]);
		for (i = 3; i >= 0; i = i - 1)
			acc(1'b0, 1'b0, {1'b0, i[2:0], `QUH_OFF_IER}, 8'h11 + i[7:0]);
		acc(1'b1, 1'b0, 8'h51, 8'h00);
		ch_irq <= 4'h4;
		repeat (3) @(posedge clk);
		#1 chk({7'h00, irq_n}, 8'h00);
		acc(1'b1, 1'b0, 8'h80, 8'h04);
		ch_irq <= 4'h0;
		acc(1'b1, 1'b1, {4'h0, `QUH_OFF_FEATURE_CONTROL_REG}, 8'h10);
		@(posedge clk);
		#1 chk({4'h0, rxd}, 8'h0E);
		acc(1'b1, 1'b1, {4'h0, `QUH_OFF_MCR}, 8'h02);
		acc(1'b1, 1'b1, {4'h0, `QUH_OFF_EFR}, 8'hC0);
		#1 chk({4'h0, rts_n}, 8'h0E);
		hold <= 4'h1;
		stall <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk({4'h0, rts_n}, 8'h0F);
		chk({4'h0, tx_ok}, 8'h0E);
		acc(1'b1, 1'b1, 8'h14, 8'h05);
		#1 chk({4'h0, dtr_n}, 8'h0D);
		acc(1'b1, 1'b1, 8'h18, 8'h20);
		#1 chk({4'h0, dtr_n}, 8'h0F);
		busy <= 4'h2;
		repeat (2) @(posedge clk);
		#1 chk({4'h0, dtr_n}, 8'h0D);
		close_out;
	end
endmodule
